// file: logic/tpc_top.sv
// Three-phase PWM output control: pattern transfer, dead time, cutoff, position retain
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/10ps
`include "tpc_params.svh"
// What this block does
// - A sawtooth-mode trigger, or a triangular-mode trigger after a buffer write, copies both pattern buffers into the output shift register.
// - First pattern drives after trigger; second takes over at one-shot falling edge.
// - Trigger: carrier underflow, transfer-request write, or carrier write with select 1 while the carrier is idle.
// - Dead time is inserted only while the dead-time disable bit is 0.
// - Special mode register takes writes only while protect release is 1.
// - Reload on carrier underflow when select 0, odd phase output when 1.
// - Each auxiliary mode bit selects A/D trigger mode when 1.
// - Interrupt source 0 is direct, 1 is counter underflow with function enabled.
// - Cutoff enabled and shutdown low puts all six pins in high impedance.
// - Shutdown low clears the output enable bit regardless of cutoff enable.
// - Output enabled, cutoff off, shutdown low: pins become plain port I/O.
// - High impedance ends only when cutoff is cleared with shutdown high.
// - Output disabled: cutoff still forces high impedance; otherwise port function.
// - Function enable dedicates the timers to carrier, phases and dead time.
// - Three position inputs, one per phase, sampled on positive phase edges.
// - Each retain edge copies the position level and holds it until the next.
// - Retain polarity 0 picks rising edges, 1 picks falling edges.
// - Top bit of the special mode register reads 0; reserved bits stored.
module tpc_top (
	input  wire logic                  CORE_CLK,
	input  wire logic                  NRST,
	input  wire tpc_pkg::tpc_bus_t     REG_BUS,
	output wire logic [`TPC_DW-1:0]    RDATA,
	input  wire logic                  CARRIER_UFLOW,
	input  wire logic                  CARRIER_RUN,
	input  wire logic                  ODD_PHASE_OUT,
	input  wire logic [`TPC_NPH-1:0]   ONESHOT,
	input  wire logic                  SHUTDOWN_N,
	input  wire logic [`TPC_NPH-1:0]   POS_IN,
	output wire logic [`TPC_NPIN-1:0]  PHASE_O,
	output wire logic [`TPC_NPIN-1:0]  PHASE_OE,
	output wire logic                  CARRIER_RELOAD,
	output wire logic                  CARRIER_IRQ,
	output wire logic [1:0]            AUX_ADTRIG,
	output wire logic                  TIMERS_DEDICATED
);

	tpc_pkg::tpc_state_t        s;
	tpc_pkg::tpc_state_t        n;
	logic                       xfer_wr;
	logic                       carr_wr;
	logic                       trig;
	logic                       xfer_go;
	logic                       spec_ok;
	logic                       sd_low;
	logic                       cut_now;
	logic                       cnt_step;
	logic                       ic_under;
	logic [`TPC_NPH-1:0]        os_fall;
	logic [`TPC_NPH-1:0]        ret_edge;
	logic [`TPC_NPIN-1:0]       pat;
	logic [`TPC_NPIN-1:0]       pwm;

	function automatic logic hit(input tpc_pkg::tpc_bus_t b, input logic [`TPC_AW-1:0] a);
		return b.wr && (b.addr == a);
	endfunction

	function automatic logic [`TPC_DW-1:0] rd_val(input tpc_pkg::tpc_state_t st,
			input logic [`TPC_AW-1:0] a);
		logic [`TPC_DW-1:0] v;
		v = 8'h00;
		case (a)
			`TPC_A_PROT: v[`TPC_B_PREL] = st.prot_rel;
			`TPC_A_CTRL0: begin
				v[`TPC_B_FEN] = st.func_en;
				v[`TPC_B_CEN] = st.cnt_en;
				v[`TPC_B_OEN] = st.out_en;
				v[`TPC_B_SAW] = st.saw_mode;
			end
			`TPC_A_CTRL1: begin
				v[`TPC_B_SSEL] = st.start_sel;
				v[`TPC_B_SUB]  = st.submode;
				v[`TPC_B_DTD]  = st.dt_dis;
			end
			`TPC_A_BUF0: v[`TPC_NPIN-1:0] = st.buf_first;
			`TPC_A_BUF1: v[`TPC_NPIN-1:0] = st.buf_second;
			`TPC_A_DEAD: v = st.dt_count;
			`TPC_A_ICNT: v[`TPC_IC_W-1:0] = st.icnt;
			`TPC_A_CARR: v = st.carrier;
			`TPC_A_PDAT: v[`TPC_NPIN-1:0] = st.port_data;
			`TPC_A_PDIR: v[`TPC_NPIN-1:0] = st.port_dir;
			`TPC_A_POS: begin
				v[`TPC_NPH-1:0] = st.ret;
				v[`TPC_B_POL]   = st.pol;
			end
			`TPC_A_SPEC: begin
				// Bit 7 has no storage and always reads zero
				v[`TPC_B_RLD]         = st.reload_sel;
				v[`TPC_B_CUT]         = st.cut_en;
				v[`TPC_B_AUX0]        = st.aux[0];
				v[`TPC_B_AUX1]        = st.aux[1];
				v[`TPC_B_ISEL]        = st.irq_sel;
				v[`TPC_B_RSV +: 2]    = st.rsv;
			end
			default: v = 8'h00;
		endcase
		return v;
	endfunction

	assign xfer_wr  = hit(REG_BUS, `TPC_A_CTRL0) && REG_BUS.wdata[`TPC_B_XREQ];
	// The carrier write only starts the phase timers while the carrier is idle
	assign carr_wr  = hit(REG_BUS, `TPC_A_CARR) && s.start_sel && !CARRIER_RUN;
	assign trig     = s.func_en && (CARRIER_UFLOW || xfer_wr || carr_wr);
	// Triangular mode transfers once per buffer update, sawtooth on every trigger
	assign xfer_go  = trig && (s.saw_mode || s.buf_new);
	assign spec_ok  = hit(REG_BUS, `TPC_A_SPEC) && s.prot_rel;
	assign sd_low   = !s.sd_s2;
	assign cut_now  = s.cut_latch || (s.cut_en && sd_low);
	assign os_fall  = s.os_prev & ~ONESHOT;
	// Mode 0 counts every underflow whatever the count enable says
	assign cnt_step = CARRIER_UFLOW && (s.cnt_en || !s.submode);
	assign ic_under = cnt_step && (s.icnt == 4'h0);

	generate
		for (genvar i = 0; i < `TPC_NPH; i++) begin : g_ph
			assign pat[2*i +: 2] = s.use_second[i] ? s.sh_second[2*i +: 2]
			                                       : s.sh_first[2*i +: 2];
			// Both legs held inactive while the dead-time count runs
			assign pwm[2*i +: 2] = (s.dt_cnt[i] != 8'h00 && !s.dt_dis) ? 2'b00
			                                                           : s.pat_q[2*i +: 2];
			assign ret_edge[i] = s.pol ? (s.pos_prev[i] & ~pwm[2*i])
			                           : (~s.pos_prev[i] & pwm[2*i]);
		end
	endgenerate

	always_comb begin
		n = s;
		n.sd_s1  = SHUTDOWN_N;
		n.sd_s2  = s.sd_s1;
		n.pos_s1 = POS_IN;
		n.pos_s2 = s.pos_s1;
		n.irq    = 1'b0;
		n.reload = 1'b0;
		n.rdata  = 8'h00;
		n.os_prev  = ONESHOT;
		n.pos_prev = {pwm[4], pwm[2], pwm[0]};

		for (int i = 0; i < `TPC_NPH; i++) begin
			if (os_fall[i]) begin
				n.use_second[i] = 1'b1;
			end
			if (pat[2*i +: 2] != s.pat_q[2*i +: 2] && !s.dt_dis) begin
				n.dt_cnt[i] = s.dt_count;
			end else if (s.dt_cnt[i] != 8'h00) begin
				n.dt_cnt[i] = s.dt_cnt[i] - 8'h01;
			end
			if (ret_edge[i]) begin
				n.ret[i] = s.pos_s2[i];
			end
		end
		n.pat_q = pat;

		if (xfer_go) begin
			n.sh_first   = s.buf_first;
			n.sh_second  = s.buf_second;
			n.use_second = 3'h0;
			n.buf_new    = 1'b0;
		end

		// Counter reloads itself from the last written value on its own underflow
		if (cnt_step) begin
			n.icnt = ic_under ? s.icnt_reload : s.icnt - 4'h1;
		end
		n.irq    = (s.irq_sel && s.func_en) ? ic_under : CARRIER_UFLOW;
		n.reload = s.reload_sel ? ODD_PHASE_OUT : CARRIER_UFLOW;

		if (hit(REG_BUS, `TPC_A_PROT)) begin
			n.prot_rel = REG_BUS.wdata[`TPC_B_PREL];
		end
		if (hit(REG_BUS, `TPC_A_CTRL0)) begin
			n.func_en  = REG_BUS.wdata[`TPC_B_FEN];
			n.cnt_en   = REG_BUS.wdata[`TPC_B_CEN];
			n.out_en   = REG_BUS.wdata[`TPC_B_OEN];
			n.saw_mode = REG_BUS.wdata[`TPC_B_SAW];
		end
		if (hit(REG_BUS, `TPC_A_CTRL1) && s.prot_rel) begin
			n.start_sel = REG_BUS.wdata[`TPC_B_SSEL];
			n.submode   = REG_BUS.wdata[`TPC_B_SUB];
			n.dt_dis    = REG_BUS.wdata[`TPC_B_DTD];
		end
		// A buffer write in the trigger cycle still marks fresh data
		if (hit(REG_BUS, `TPC_A_BUF0)) begin
			n.buf_first = REG_BUS.wdata[`TPC_NPIN-1:0];
			n.buf_new   = 1'b1;
		end
		if (hit(REG_BUS, `TPC_A_BUF1)) begin
			n.buf_second = REG_BUS.wdata[`TPC_NPIN-1:0];
			n.buf_new    = 1'b1;
		end
		if (hit(REG_BUS, `TPC_A_DEAD)) begin
			n.dt_count = REG_BUS.wdata;
		end
		// Software must not collide with an underflow here; the write wins if it does
		if (hit(REG_BUS, `TPC_A_ICNT)) begin
			n.icnt        = REG_BUS.wdata[`TPC_IC_W-1:0];
			n.icnt_reload = REG_BUS.wdata[`TPC_IC_W-1:0];
		end
		if (hit(REG_BUS, `TPC_A_CARR)) begin
			n.carrier = REG_BUS.wdata;
		end
		if (hit(REG_BUS, `TPC_A_PDAT)) begin
			n.port_data = REG_BUS.wdata[`TPC_NPIN-1:0];
		end
		if (hit(REG_BUS, `TPC_A_PDIR)) begin
			n.port_dir = REG_BUS.wdata[`TPC_NPIN-1:0];
		end
		if (hit(REG_BUS, `TPC_A_POS)) begin
			n.pol = REG_BUS.wdata[`TPC_B_POL];
		end
		if (spec_ok) begin
			n.reload_sel = REG_BUS.wdata[`TPC_B_RLD];
			n.cut_en     = REG_BUS.wdata[`TPC_B_CUT];
			n.aux[0]     = REG_BUS.wdata[`TPC_B_AUX0];
			n.aux[1]     = REG_BUS.wdata[`TPC_B_AUX1];
			n.irq_sel    = REG_BUS.wdata[`TPC_B_ISEL];
			n.rsv        = REG_BUS.wdata[`TPC_B_RSV +: 2];
		end

		// Hardware clear wins over a software set so shutdown cannot be overridden
		if (sd_low) begin
			n.out_en = 1'b0;
		end
		if (s.cut_en && sd_low) begin
			n.cut_latch = 1'b1;
		end else if (!s.cut_en && !sd_low) begin
			n.cut_latch = 1'b0;
		end

		if (cut_now) begin
			n.phase_o  = 6'h00;
			n.phase_oe = 6'h00;
		end else if (s.out_en && s.func_en) begin
			n.phase_o  = pwm;
			n.phase_oe = `TPC_ALL_PINS;
		end else begin
			n.phase_o  = s.port_data;
			n.phase_oe = s.port_dir;
		end

		if (REG_BUS.rd) begin
			n.rdata = rd_val(s, REG_BUS.addr);
		end
	end

	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign RDATA            = s.rdata;
	assign PHASE_O          = s.phase_o;
	assign PHASE_OE         = s.phase_oe;
	assign CARRIER_RELOAD   = s.reload;
	assign CARRIER_IRQ      = s.irq;
	assign AUX_ADTRIG       = s.aux;
	assign TIMERS_DEDICATED = s.func_en;

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!NRST);

	sequence seq_xfer;
		xfer_go && !(|os_fall);
	endsequence

	sequence seq_first_out;
		s.sh_first == $past(s.buf_first) && s.use_second == 3'h0;
	endsequence

	sequence seq_sd_port;
		!cut_now && sd_low;
	endsequence

	a_xfer_copy: assert property (seq_xfer |=> seq_first_out)
		else $error("transfer did not load the first pattern");

	a_second_take: assert property ((os_fall[0] && !xfer_go) |=>
		(s.use_second[0] && pat[1:0] == s.sh_second[1:0]))
		else $error("second pattern not taken at one-shot fall");

	a_trig_src: assert property ((s.func_en && CARRIER_UFLOW && s.saw_mode) |=>
		s.sh_second == $past(s.buf_second))
		else $error("carrier underflow did not transfer");

	a_dt_bypass: assert property (s.dt_dis |-> pwm == s.pat_q)
		else $error("dead time applied while disabled");

	a_dt_gap: assert property ((!s.dt_dis && s.dt_cnt[0] != 8'h00) |-> pwm[1:0] == 2'b00)
		else $error("phase driven during dead time");

	a_prot_block: assert property ((hit(REG_BUS, `TPC_A_SPEC) && !s.prot_rel) |=>
		($stable(s.cut_en) && $stable(s.reload_sel) && $stable(s.irq_sel)))
		else $error("protected register written without release");

	a_reload_src: assert property ((!s.reload_sel && CARRIER_UFLOW) ##1 1'b1 |->
		CARRIER_RELOAD)
		else $error("reload missing on carrier underflow");

	a_irq_direct: assert property (((!s.irq_sel || !s.func_en) && CARRIER_UFLOW) |=>
		CARRIER_IRQ)
		else $error("direct carrier interrupt missing");

	a_irq_count: assert property ((s.irq_sel && s.func_en && !ic_under) |=> !CARRIER_IRQ)
		else $error("counted interrupt without counter underflow");

	a_cut_hiz: assert property ((s.cut_en && sd_low) |=> PHASE_OE == 6'h00)
		else $error("pins driven during forced cutoff");

	a_sd_clear: assert property (sd_low |=> !s.out_en)
		else $error("output enable survived shutdown");

	a_cut_hold: assert property ((s.cut_latch && s.cut_en) |=> s.cut_latch)
		else $error("cutoff released while still enabled");

	a_port_mode: assert property ((!cut_now && !s.out_en) |=>
		(PHASE_O == $past(s.port_data) && PHASE_OE == $past(s.port_dir)))
		else $error("pins not in port mode");

	a_ret_take: assert property (ret_edge[1] |=> s.ret[1] == $past(s.pos_s2[1]))
		else $error("position level not retained on edge");

	a_ret_hold: assert property (!ret_edge[2] |=> $stable(s.ret[2]))
		else $error("retained position changed without edge");

	a_b7_zero: assert property ((REG_BUS.rd && REG_BUS.addr == `TPC_A_SPEC) |=> !RDATA[7])
		else $error("unassigned special mode bit read as one");

	a_xfer_gate: assert property (!s.func_en |=>
		($stable(s.sh_first) && $stable(s.sh_second)))
		else $error("pattern transfer while function disabled");

	a_tri_once: assert property ((trig && !s.saw_mode && !s.buf_new) |=>
		$stable(s.sh_first))
		else $error("triangular mode transferred without new buffer data");

	a_dt_load: assert property ((!s.dt_dis && pat[1:0] != s.pat_q[1:0]) |=>
		s.dt_cnt[0] == $past(s.dt_count))
		else $error("dead-time count not started on pattern change");

	a_reload_odd: assert property ((s.reload_sel && ODD_PHASE_OUT) |=> CARRIER_RELOAD)
		else $error("reload missing on odd phase output");

	a_reload_none: assert property ((!ODD_PHASE_OUT && !CARRIER_UFLOW) |=>
		!CARRIER_RELOAD)
		else $error("reload without a reload event");

	a_aux_mode: assert property (spec_ok |=>
		AUX_ADTRIG == $past(REG_BUS.wdata[`TPC_B_AUX1:`TPC_B_AUX0]))
		else $error("auxiliary trigger mode not taken from write");

	a_ded_follow: assert property (hit(REG_BUS, `TPC_A_CTRL0) |=>
		TIMERS_DEDICATED == $past(REG_BUS.wdata[`TPC_B_FEN]))
		else $error("timer dedication does not follow function enable");

	a_pwm_drive: assert property ((!cut_now && s.out_en && s.func_en) |=>
		(PHASE_OE == `TPC_ALL_PINS && PHASE_O == $past(pwm)))
		else $error("phase pins not carrying the pattern");

	a_cut_clear: assert property ((s.cut_latch && !s.cut_en && !sd_low) |=>
		!s.cut_latch)
		else $error("cutoff not released with enable clear and shutdown high");

	a_ret_ro: assert property ((hit(REG_BUS, `TPC_A_POS) && !ret_edge[0]) |=>
		$stable(s.ret[0]))
		else $error("retained position changed by a write");

	a_irq_counted: assert property ((s.irq_sel && s.func_en && ic_under) |=>
		CARRIER_IRQ)
		else $error("counter underflow did not raise the interrupt");

	a_sd_port: assert property (seq_sd_port ##1 seq_sd_port |=>
		(PHASE_O == $past(s.port_data) && PHASE_OE == $past(s.port_dir)))
		else $error("pins not returned to port use on shutdown");

endmodule

// file: logic/tpc_params.svh
// Register map, field positions and widths of the three-phase output control block
`ifndef TPC_PARAMS_SVH
`define TPC_PARAMS_SVH
`define TPC_AW        12
`define TPC_DW        8
`define TPC_DT_W      8
`define TPC_IC_W      4
`define TPC_NPH       3
`define TPC_NPIN      6
`define TPC_A_PROT    12'h00A
`define TPC_A_CTRL0   12'h348
`define TPC_A_CTRL1   12'h349
`define TPC_A_BUF0    12'h34A
`define TPC_A_BUF1    12'h34B
`define TPC_A_DEAD    12'h34C
`define TPC_A_ICNT    12'h34D
`define TPC_A_CARR    12'h34E
`define TPC_A_PDAT    12'h34F
`define TPC_A_PDIR    12'h350
`define TPC_A_POS     12'h351
`define TPC_A_SPEC    12'h39E
`define TPC_B_PREL    1
`define TPC_B_FEN     0
`define TPC_B_CEN     1
`define TPC_B_OEN     2
`define TPC_B_SAW     3
`define TPC_B_XREQ    4
`define TPC_B_SSEL    0
`define TPC_B_SUB     1
`define TPC_B_DTD     2
`define TPC_B_RLD     0
`define TPC_B_CUT     1
`define TPC_B_AUX0    2
`define TPC_B_AUX1    3
`define TPC_B_ISEL    4
`define TPC_B_RSV     5
`define TPC_B_POL     3
`define TPC_ALL_PINS  6'h3F
`endif

// file: logic/tpc_pkg.sv
// Types of the three-phase output control block
`include "tpc_params.svh"
package tpc_pkg;
	typedef struct packed {
		logic [`TPC_AW-1:0] addr;
		logic [`TPC_DW-1:0] wdata;
		logic               wr;
		logic               rd;
	} tpc_bus_t;

	typedef struct packed {
		logic                               prot_rel;
		logic                               func_en;
		logic                               cnt_en;
		logic                               out_en;
		logic                               saw_mode;
		logic                               start_sel;
		logic                               submode;
		logic                               dt_dis;
		logic [`TPC_NPIN-1:0]               buf_first;
		logic [`TPC_NPIN-1:0]               buf_second;
		logic                               buf_new;
		logic [`TPC_DT_W-1:0]               dt_count;
		logic [`TPC_IC_W-1:0]               icnt_reload;
		logic [`TPC_IC_W-1:0]               icnt;
		logic [`TPC_DW-1:0]                 carrier;
		logic                               reload_sel;
		logic                               cut_en;
		logic [1:0]                         aux;
		logic                               irq_sel;
		logic [1:0]                         rsv;
		logic [`TPC_NPIN-1:0]               port_data;
		logic [`TPC_NPIN-1:0]               port_dir;
		logic                               pol;
		logic [`TPC_NPH-1:0]                ret;
		logic [`TPC_NPIN-1:0]               sh_first;
		logic [`TPC_NPIN-1:0]               sh_second;
		logic [`TPC_NPH-1:0]                use_second;
		logic [`TPC_NPIN-1:0]               pat_q;
		logic [`TPC_NPH-1:0][`TPC_DT_W-1:0] dt_cnt;
		logic [`TPC_NPH-1:0]                pos_prev;
		logic [`TPC_NPH-1:0]                os_prev;
		logic                               sd_s1;
		logic                               sd_s2;
		logic [`TPC_NPH-1:0]                pos_s1;
		logic [`TPC_NPH-1:0]                pos_s2;
		logic                               cut_latch;
		logic [`TPC_NPIN-1:0]               phase_o;
		logic [`TPC_NPIN-1:0]               phase_oe;
		logic [`TPC_DW-1:0]                 rdata;
		logic                               irq;
		logic                               reload;
	} tpc_state_t;
endpackage

// file: logic/README_none.sv
// Holds no logic; all logic of the block lives in tpc_top.sv

// file: verif/tpc_bridge_model.sv
// Motor power bridge and hall sensor model facing the six phase pins
`timescale 1ns/10ps
module tpc_bridge_model (
	input  wire logic [5:0] phase_o,
	input  wire logic [5:0] phase_oe,
	input  wire logic [2:0] hall_cmd,
	input  wire logic       sd_fault,
	output wire logic [2:0] pos_in,
	output wire logic       shutdown_n,
	output wire logic [5:0] gate_lvl
);
	// Gate driver inputs carry pull-downs, so a released pin reads as leg off
	assign gate_lvl = phase_o & phase_oe;
	// Hall sensors follow the rotor position that the bench commands
	assign pos_in = hall_cmd;
	// Shutdown line has an external pull-up; the fault detector pulls it low
	assign shutdown_n = ~sd_fault;
endmodule

// file: verif/tb_top.sv
// Self-checking bench of the three-phase output control block
`timescale 1ns/10ps
`include "tpc_params.svh"
module tb_top;
	logic              clk;
	logic              nrst;
	tpc_pkg::tpc_bus_t bus;
	logic              uf;
	logic              odd;
	logic [2:0]        os;
	logic [2:0]        hall;
	logic              fault;
	logic              run;
	wire logic [7:0]   rdata;
	wire logic [5:0]   ph_o;
	wire logic [5:0]   ph_oe;
	wire logic [2:0]   pos;
	wire logic         sd_n;
	wire logic         reload;
	wire logic         irq;
	wire logic [1:0]   aux;
	wire logic         ded;
	wire logic [5:0]   gate;
	int                miscompares = 0;
	int                checks = 0;

	tpc_top tpc_top_i (.CORE_CLK(clk), .NRST(nrst), .REG_BUS(bus), .RDATA(rdata),
		.CARRIER_UFLOW(uf), .CARRIER_RUN(run), .ODD_PHASE_OUT(odd), .ONESHOT(os),
		.SHUTDOWN_N(sd_n), .POS_IN(pos), .PHASE_O(ph_o), .PHASE_OE(ph_oe),
		.CARRIER_RELOAD(reload), .CARRIER_IRQ(irq), .AUX_ADTRIG(aux),
		.TIMERS_DEDICATED(ded));
	tpc_bridge_model tpc_bridge_model_i (.phase_o(ph_o), .phase_oe(ph_oe), .hall_cmd(hall),
		.sd_fault(fault), .pos_in(pos), .shutdown_n(sd_n), .gate_lvl(gate));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task close_out;
		$display("checks=%0d miscompares=%0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task chk(input logic [7:0] g, input logic [7:0] e);
		checks++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task wr(input logic [11:0] a, input logic [7:0] d);
		bus.addr <= a;
		bus.wdata <= d;
		bus.wr <= 1'b1;
		@(posedge clk);
		bus.wr <= 1'b0;
		@(posedge clk);
	endtask

	// Read data stand only in the cycle after the strobe
	task rd(input logic [11:0] a, input logic [7:0] e);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge clk);
		bus.rd <= 1'b0;
		#1;
		chk(rdata, e);
		@(posedge clk);
	endtask

	task pulse_uf;
		uf <= 1'b1;
		@(posedge clk);
		uf <= 1'b0;
		#1;
	endtask

	task t_reset;
		rd(`TPC_A_SPEC, 8'h00);
		rd(`TPC_A_CTRL0, 8'h00);
		rd(12'h7FF, 8'h00);
		chk({2'h0, ph_oe}, 8'h00);
	endtask

	task t_protect;
		wr(`TPC_A_SPEC, 8'h0E);
		rd(`TPC_A_SPEC, 8'h00);
		wr(`TPC_A_PROT, 8'h02);
		wr(`TPC_A_SPEC, 8'h8C);
		rd(`TPC_A_SPEC, 8'h0C);
		chk({6'h0, aux}, 8'h03);
		wr(`TPC_A_SPEC, 8'h00);
		chk({6'h0, aux}, 8'h00);
	endtask

	task t_xfer;
		wr(`TPC_A_CTRL1, 8'h04);
		wr(`TPC_A_CTRL0, 8'h05);
		chk({7'h0, ded}, 8'h01);
		wr(`TPC_A_POS, 8'h00);
		hall <= 3'b101;
		os <= 3'h7;
		wr(`TPC_A_BUF0, 8'h15);
		wr(`TPC_A_BUF1, 8'h2A);
		pulse_uf();
		cyc(4);
		chk({2'h0, ph_o}, 8'h15);
		chk({2'h0, ph_oe}, 8'h3F);
		rd(`TPC_A_POS, 8'h05);
		hall <= 3'b010;
		cyc(4);
		os <= 3'h0;
		cyc(4);
		chk({2'h0, ph_o}, 8'h2A);
		rd(`TPC_A_POS, 8'h05);
		wr(`TPC_A_POS, 8'h0F);
		rd(`TPC_A_POS, 8'h0D);
		os <= 3'h7;
		wr(`TPC_A_BUF0, 8'h15);
		wr(`TPC_A_CTRL0, 8'h15);
		cyc(4);
		chk({2'h0, ph_o}, 8'h15);
		os <= 3'h0;
		cyc(4);
		rd(`TPC_A_POS, 8'h0A);
		wr(`TPC_A_CTRL1, 8'h05);
		wr(`TPC_A_BUF0, 8'h15);
		// A carrier write while the carrier runs must not start a transfer
		run <= 1'b1;
		wr(`TPC_A_CARR, 8'h10);
		cyc(4);
		chk({2'h0, ph_o}, 8'h2A);
		run <= 1'b0;
		wr(`TPC_A_CARR, 8'h10);
		cyc(4);
		chk({2'h0, ph_o}, 8'h15);
	endtask

	task t_dead;
		int n;
		wr(`TPC_A_CTRL1, 8'h00);
		wr(`TPC_A_DEAD, 8'h06);
		wr(`TPC_A_BUF0, 8'h2A);
		pulse_uf();
		n = 0;
		while (ph_o !== 6'h2A && n < 40) begin
			@(posedge clk);
			#1;
			n++;
		end
		// Two pipeline cycles plus six dead-time cycles with both legs low
		chk(n[7:0], 8'h08);
	endtask

	task t_cut;
		wr(`TPC_A_SPEC, 8'h02);
		fault <= 1'b1;
		cyc(5);
		chk({2'h0, ph_oe}, 8'h00);
		chk({2'h0, gate}, 8'h00);
		rd(`TPC_A_CTRL0, 8'h01);
		fault <= 1'b0;
		cyc(5);
		chk({2'h0, ph_oe}, 8'h00);
		wr(`TPC_A_SPEC, 8'h00);
		wr(`TPC_A_CTRL0, 8'h05);
		cyc(4);
		chk({2'h0, ph_oe}, 8'h3F);
		wr(`TPC_A_PDIR, 8'h0F);
		wr(`TPC_A_PDAT, 8'h05);
		fault <= 1'b1;
		cyc(5);
		chk({2'h0, ph_oe}, 8'h0F);
		chk({2'h0, ph_o & ph_oe}, 8'h05);
		fault <= 1'b0;
		cyc(4);
		wr(`TPC_A_SPEC, 8'h02);
		fault <= 1'b1;
		cyc(5);
		chk({2'h0, ph_oe}, 8'h00);
		fault <= 1'b0;
		cyc(4);
		wr(`TPC_A_SPEC, 8'h00);
		cyc(4);
		chk({2'h0, ph_oe}, 8'h0F);
	endtask

	task t_irq;
		wr(`TPC_A_CTRL0, 8'h01);
		pulse_uf();
		chk({6'h0, irq, reload}, 8'h03);
		wr(`TPC_A_CTRL1, 8'h02);
		wr(`TPC_A_SPEC, 8'h01);
		odd <= 1'b1;
		@(posedge clk);
		odd <= 1'b0;
		#1;
		chk({7'h0, reload}, 8'h01);
		pulse_uf();
		chk({7'h0, reload}, 8'h00);
		wr(`TPC_A_CTRL1, 8'h00);
		wr(`TPC_A_SPEC, 8'h10);
		wr(`TPC_A_ICNT, 8'h02);
		for (int i = 0; i < 3; i++) begin
			pulse_uf();
			chk({7'h0, irq}, {7'h0, i == 2});
		end
	endtask

	initial begin
		nrst = 1'b0;
		bus = '0;
		uf = 1'b0;
		odd = 1'b0;
		os = 3'h0;
		hall = 3'h0;
		fault = 1'b0;
		run = 1'b0;
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		cyc(4);
		t_reset();
		t_protect();
		t_xfer();
		t_dead();
		t_cut();
		t_irq();
		close_out();
	end

	// A hang costs this span of 8000 cycles, over 40 times the expected 180 or so cycles
	initial begin
		#200000;
		miscompares++;
		close_out();
	end
endmodule
